/* common/tx_filter_map.vh */
`ifndef TX_FILTER_MAP_VH
`define TX_FILTER_MAP_VH
`define SEL_IN_TX_BIT        32
`define SEL_EXCL_ABORT_BIT   33
`define SEL_EVENT_LO         0
`define SEL_EVENT_HI         7
`define SEL_UMASK_LO         8
`define SEL_UMASK_HI         15
`define ELISION_ABORT_CODE   8'hC8
`define RESTRICT_ABORT_CODE  8'hC9
`define ABORT_UMASK          8'h04
`define ABW_CYC_HI           31
`define ABW_ELISION          32
`define ABW_RESTRICT         33
`define ABW_INSTR            34
`define ABW_NON_INSTR        35
`define ABW_RETRY            36
`define ABW_CONFLICT         37
`define ABW_CAP_WR           38
`define ABW_CAP_RD           39
`define ABW_RSVD_W           24
`define ABW_CYC_LO           0
`define NUM_SEL              4
`define ZERO64               64'h0000000000000000
`define ZERO32               32'h00000000
`define CYC_STEP             32'h00000001
`define COUNTER_TWO_IDX      2'h2
`define REC_RESUME_OFS       8'h08
`define REC_TRIG_IP_OFS      8'hB0
`define REC_ABORT_OFS        8'hB8
`define COUNTER_TWO          2
`endif

/* design/transactional_event_filter.v */
`timescale 1ns/1ns
`include "tx_filter_map.vh"
module transactional_event_filter #(
  parameter CNT_W = 48
) (
  input  wire             clk,
  input  wire             arst_n,
  input  wire [1:0]       sel_idx,
  input  wire             sel_we,
  input  wire [63:0]      sel_wdata,
  output reg  [63:0]      event_select_register,
  input  wire             tx_support,
  input  wire             region_begin,
  input  wire             region_commit,
  input  wire             region_abort,
  input  wire             region_elision,
  input  wire [63:0]      region_resume_ip,
  input  wire [3:0]       event_in,
  input  wire             abort_instr,
  input  wire             abort_retry,
  input  wire             abort_conflict,
  input  wire             abort_cap_wr,
  input  wire             abort_cap_rd,
  input  wire [63:0]      retire_ip,
  input  wire [3:0]       sample_req,
  output wire             abort_request,
  output reg  [4*CNT_W-1:0] counters,
  output reg              record_valid,
  output reg  [63:0]      record_resume_ip,
  output reg  [63:0]      record_trig_ip,
  output reg  [63:0]      record_abort_info,
  output reg              restart_elided,
  output reg              go_fallback
);

// ----------------------------------------------------------------
// Local sizes
// ----------------------------------------------------------------
localparam NCNT  = `NUM_SEL;
localparam CYC_W = `ABW_CYC_HI - `ABW_CYC_LO + 1;

// ----------------------------------------------------------------
// Select registers and region state
// ----------------------------------------------------------------
reg  [63:0]        sel_reg [0:NCNT-1];
reg                in_region_reg;
reg                in_region_next;
reg  [CYC_W-1:0]   cyc_reg;
reg  [CYC_W-1:0]   cyc_next;
reg  [CNT_W-1:0]   snap_reg;
reg  [CNT_W-1:0]   snap_next;
reg                sample_pend_reg;
reg                sample_pend_next;
reg  [63:0]        pend_ip_reg;
reg  [63:0]        pend_ip_next;
reg  [4*CNT_W-1:0] counters_next;
reg  [NCNT-1:0]    abort_samp;
reg                record_fire;
reg                restart_next;
reg                fallback_next;
reg  [63:0]        resume_next;
reg  [63:0]        abort_info_next;
reg  [63:0]        trig_ip_next;
wire               any_sample;
wire               aborting;
integer            i;
integer            k;
integer            n;

// ----------------------------------------------------------------
// Helper functions
// ----------------------------------------------------------------
// Select word names one of the two abort events
function is_abort_event;
  input [63:0] s;
  begin
    is_abort_event = (s[`SEL_UMASK_HI:`SEL_UMASK_LO] == `ABORT_UMASK) &&
      (s[`SEL_EVENT_HI:`SEL_EVENT_LO] == `ELISION_ABORT_CODE ||
       s[`SEL_EVENT_HI:`SEL_EVENT_LO] == `RESTRICT_ABORT_CODE);
  end
endfunction

// Counter increment by one
function [CNT_W-1:0] bump;
  input [CNT_W-1:0] v;
  begin
    bump = v + {{CNT_W-1{1'b0}}, 1'b1};
  end
endfunction

// Event passes the in-region filter
function passes_filter;
  input [63:0] s;
  input        ev;
  input        in_reg;
  begin
    // In-region-only drops events outside regions
    passes_filter = ev && (!s[`SEL_IN_TX_BIT] || in_reg);
  end
endfunction

// Select word as stored after a write
function [63:0] filter_write;
  input [63:0] d;
  input        sup;
  input [1:0]  idx;
  begin
    filter_write = d;
    // Filter bits only kept with transactional support
    filter_write[`SEL_IN_TX_BIT] = d[`SEL_IN_TX_BIT] & sup;
    filter_write[`SEL_EXCL_ABORT_BIT] = d[`SEL_EXCL_ABORT_BIT] & sup &
      (idx == `COUNTER_TWO_IDX);
  end
endfunction

// Abort information word
function [63:0] make_abort_word;
  input [CYC_W-1:0] cyc;
  input             elis;
  input             instr;
  input             retry;
  input             conflict;
  input             cap_wr;
  input             cap_rd;
  begin
    make_abort_word = `ZERO64;
    make_abort_word[`ABW_CYC_HI:`ABW_CYC_LO] = cyc;
    make_abort_word[`ABW_ELISION]   = elis;
    make_abort_word[`ABW_RESTRICT]  = ~elis;
    make_abort_word[`ABW_INSTR]     = instr;
    make_abort_word[`ABW_NON_INSTR] = ~instr;
    make_abort_word[`ABW_RETRY]     = retry;
    make_abort_word[`ABW_CONFLICT]  = conflict;
    make_abort_word[`ABW_CAP_WR]    = cap_wr;
    make_abort_word[`ABW_CAP_RD]    = cap_rd;
  end
endfunction

// Word left by a committed region
function [63:0] make_commit_word;
  input [CYC_W-1:0] cyc;
  begin
    make_commit_word = `ZERO64;
    make_commit_word[`ABW_CYC_HI:`ABW_CYC_LO] = cyc;
  end
endfunction

// ----------------------------------------------------------------
// Request decode
// ----------------------------------------------------------------
assign any_sample = |sample_req;
// Sampling inside a region forces the abort first
assign abort_request = in_region_reg &
                       (any_sample | sample_pend_reg);
assign aborting      = in_region_reg & (region_abort | abort_request);

// Select register readback
always @* begin
  event_select_register = sel_reg[sel_idx];
end

// Abort events that ask for a record
always @* begin
  for (i = 0; i < NCNT; i = i + 1)
    abort_samp[i] = event_in[i] & is_abort_event(sel_reg[i]);
end

// ----------------------------------------------------------------
// Select register write
// ----------------------------------------------------------------
always @(posedge clk or negedge arst_n) begin
  if (!arst_n) begin
    for (k = 0; k < NCNT; k = k + 1)
      sel_reg[k] <= `ZERO64;
  end else if (sel_we) begin
    sel_reg[sel_idx] <= filter_write(sel_wdata, tx_support,
                                     sel_idx);
  end
end

// ----------------------------------------------------------------
// Region tracking
// ----------------------------------------------------------------
always @* begin
  in_region_next = in_region_reg;
  cyc_next       = cyc_reg;
  snap_next      = snap_reg;
  if (region_begin && !in_region_reg) begin
    in_region_next = 1'b1;
    cyc_next       = `ZERO32;
    // Counter two value to restore on abort
    snap_next      = counters[`COUNTER_TWO*CNT_W +: CNT_W];
  end else if (in_region_reg) begin
    cyc_next = cyc_reg + `CYC_STEP;
    if (aborting || region_commit)
      in_region_next = 1'b0;
  end
end

always @(posedge clk or negedge arst_n) begin
  if (!arst_n) begin
    in_region_reg <= 1'b0;
    cyc_reg       <= `ZERO32;
    snap_reg      <= {CNT_W{1'b0}};
  end else begin
    in_region_reg <= in_region_next;
    cyc_reg       <= cyc_next;
    snap_reg      <= snap_next;
  end
end

// ----------------------------------------------------------------
// Counters and filtering
// ----------------------------------------------------------------
always @* begin
  counters_next = counters;
  for (n = 0; n < NCNT; n = n + 1) begin
    if (passes_filter(sel_reg[n], event_in[n], in_region_reg))
      counters_next[n*CNT_W +: CNT_W] = bump(counters[n*CNT_W +: CNT_W]);
  end
  // Abort restores counter two to its value at region begin when its exclusion bit is set
  if (aborting && sel_reg[`COUNTER_TWO][`SEL_EXCL_ABORT_BIT])
    counters_next[`COUNTER_TWO*CNT_W +: CNT_W] = snap_reg;
end

always @(posedge clk or negedge arst_n) begin
  if (!arst_n) begin
    counters <= {4*CNT_W{1'b0}};
  end else begin
    counters <= counters_next;
  end
end

// ----------------------------------------------------------------
// Sampling control
// ----------------------------------------------------------------
always @* begin
  sample_pend_next = sample_pend_reg;
  pend_ip_next     = pend_ip_reg;
  record_fire      = 1'b0;
  if (aborting) begin
    // Record waits until the abort has taken place
    if (any_sample || sample_pend_reg || |abort_samp) begin
      sample_pend_next = 1'b1;
      if (any_sample)
        pend_ip_next = retire_ip;
    end
  end else if (sample_pend_reg || any_sample || |abort_samp) begin
    sample_pend_next = 1'b0;
    record_fire      = 1'b1;
  end
end

always @(posedge clk or negedge arst_n) begin
  if (!arst_n) begin
    sample_pend_reg <= 1'b0;
    pend_ip_reg     <= `ZERO64;
  end else begin
    sample_pend_reg <= sample_pend_next;
    pend_ip_reg     <= pend_ip_next;
  end
end

// ----------------------------------------------------------------
// Record next values
// ----------------------------------------------------------------
always @* begin
  restart_next    = aborting & region_elision;
  fallback_next   = aborting & ~region_elision;
  resume_next     = record_resume_ip;
  abort_info_next = record_abort_info;
  trig_ip_next    = record_trig_ip;
  if (aborting) begin
    resume_next     = region_resume_ip;
    abort_info_next = make_abort_word(cyc_reg, region_elision,
      abort_instr, abort_retry, abort_conflict, abort_cap_wr,
      abort_cap_rd);
  end else if (region_commit && in_region_reg) begin
    abort_info_next = make_commit_word(cyc_reg);
  end
  if (record_fire)
    trig_ip_next = sample_pend_reg ? pend_ip_reg : retire_ip;
end

// ----------------------------------------------------------------
// Sampling record
// ----------------------------------------------------------------
always @(posedge clk or negedge arst_n) begin
  if (!arst_n) begin
    record_valid      <= 1'b0;
    record_resume_ip  <= `ZERO64;
    record_trig_ip    <= `ZERO64;
    record_abort_info <= `ZERO64;
    restart_elided    <= 1'b0;
    go_fallback       <= 1'b0;
  end else begin
    record_valid      <= record_fire;
    record_resume_ip  <= resume_next;
    record_trig_ip    <= trig_ip_next;
    record_abort_info <= abort_info_next;
    restart_elided    <= restart_next;
    go_fallback       <= fallback_next;
  end
end
endmodule

/* test/tef_chk_sva.sv */
`timescale 1ns/1ns
module tef_chk (
  input wire        clk, arst_n, region_abort, region_elision,
  input wire        abort_request, record_valid, restart_elided, go_fallback,
  input wire [1:0]  sel_idx,
  input wire [63:0] event_select_register, record_abort_info
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_ELIS: assert property (region_abort && region_elision
    |=> restart_elided) else $error("restart");
  AST_FALL: assert property (region_abort && !region_elision
    |=> go_fallback) else $error("fallback");
  AST_ONE: assert property (!(restart_elided && go_fallback))
    else $error("two exits");
  AST_REQ: assert property (abort_request
    |=> restart_elided || go_fallback) else $error("abort");
  AST_REC: assert property (abort_request |-> ##2 record_valid)
    else $error("record");
  AST_RSVD: assert property (record_valid
    |-> record_abort_info[63:40] == 24'H0) else $error("reserved");
  AST_KIND: assert property (record_valid && record_abort_info[32]
    |-> !record_abort_info[33]) else $error("kind");
  AST_EXCL: assert property (sel_idx != 2'H2
    |-> !event_select_register[33]) else $error("exclusion");
  C_AB: cover property (region_abort);
  C_REQ: cover property (abort_request);
  C_REC: cover property (record_valid);
endmodule
bind transactional_event_filter tef_chk chk_u (.clk, .arst_n,
  .region_abort, .region_elision, .abort_request, .record_valid,
  .restart_elided, .go_fallback, .sel_idx, .event_select_register,
  .record_abort_info);

/* test/testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic [63:0] sm [4], sel_wdata = 0, rip = 0, tip = 0, w, rd, rt, rr, ab;
  logic [47:0] m [4] = '{default: 0}, snap;
  logic [191:0] cn;
  logic [4:0] c = 0;
  logic [3:0] ev = 0, sq = 0;
  logic [1:0] si = 0;
  logic clk = 0, arst_n = 0, we = 0, tx = 1, rb = 0, rc = 0, ra = 0, re = 0;
  logic inr = 0, aq, rv, rs, fb;
  integer fail_count = 0, n_checks = 0, seed = 32'H5A1D4BEC, i, j, nc;
  transactional_event_filter dut_u (.clk, .arst_n, .sel_idx(si), .sel_we(we),
    .sel_wdata, .event_select_register(rd), .tx_support(tx),
    .region_begin(rb), .region_commit(rc), .region_abort(ra),
    .region_elision(re), .region_resume_ip(rip), .event_in(ev),
    .abort_instr(c[0]), .abort_retry(c[1]), .abort_conflict(c[2]),
    .abort_cap_wr(c[3]), .abort_cap_rd(c[4]), .retire_ip(tip),
    .sample_req(sq), .abort_request(aq), .counters(cn), .record_valid(rv),
    .record_resume_ip(rr), .record_trig_ip(rt), .record_abort_info(ab),
    .restart_elided(rs), .go_fallback(fb));
  always #5 clk = ~clk;
  initial begin #100000; fail_count++; end_sim; end
  task automatic chk(input string s, input logic [63:0] e, g);
    n_checks++;
    if (g !== e) fail_count++;
    if (g !== e) $display("mismatch %s exp %h got %h", s, e, g);
  endtask
  task automatic step; @(posedge clk); #1; endtask
  task automatic cyc(input logic [3:0] e);
    ev = e;
    for (int k = 0; k < 4; k++)
      if (e[k] && (inr || !sm[k][32])) m[k]++;
    step;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic region(input logic e, input integer h);
    ev = 0; re = e; rb = 1; snap = m[2];
    step;
    rb = 0; inr = 1;
    nc = 3 + ($random(seed) & 7);
    repeat (nc) cyc($random(seed));
    rip = {$random(seed), $random(seed)}; tip = ~rip; c = $random(seed);
    w = {24'H0, c[4:1], ~c[0], c[0], ~e, e, 32'H0};
    w[31:0] = nc;
    ev = 0; rc = h == 0; ra = h == 1; sq = {h == 2, 2'H0};
    #1 if (h == 2) chk("abort request", 1, aq);
    step;
    rc = 0; ra = 0; sq = 0; inr = 0;
    if (h && sm[2][33]) m[2] = snap;
    if (h) chk("exit", {e, ~e}, {rs, fb});
    chk("cycle word", h ? w : {32'H0, nc[31:0]}, ab);
    if (h == 2) begin
      step;
      chk("record", 1, rv);
      chk("trigger ip", tip, rt);
      chk("resume ip", rip, rr);
      chk("abort word", w, ab);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 arst_n = 1;
    tx = 0; we = 1; si = 1; sel_wdata = {$random(seed), $random(seed)};
    step;
    chk("select no support", sel_wdata & 64'HFFFFFFFCFFFFFFFF, rd);
    tx = 1;
    for (i = 0; i < 4; i++) begin
      si = i[1:0];
      sel_wdata = {$random(seed), $random(seed)} | 64'H200000000;
      sel_wdata[32] = i[0];
      sm[i] = sel_wdata;
      sm[i][33] = i == 2;
      step;
      chk("select", sm[i], rd);
    end
    we = 0;
    for (j = 0; j < 6; j++) begin
      repeat (4) cyc($random(seed));
      region(j[0], j % 3);
      for (i = 0; i < 4; i++) chk("counter", m[i], cn[i*48 +: 48]);
    end
    end_sim;
  end
endmodule
